// ---- verilog/nbc_host.sv ----
// Host controller driving a parallel flash over its bus-cycle pins.
// Assumes the device pins are sampled on MCLK and need no other timing.
`timescale 1ns/1ps
`default_nettype none
module nbc_host
    import nbc_pkg::*;
(
    input  wire logic             MCLK,
    input  wire logic             RST_N,
    input  wire logic             X16,
    input  wire logic             BIG,
    input  wire logic             REQ_VALID,
    input  wire nbc_pkg::nbc_req_s REQ,
    output var  logic             REQ_READY,
    output var  logic             RD_VALID,
    output var  logic [15:0]      RD_DATA,
    input  wire logic             RD_READY,
    output var  logic             DEV_BUSY,
    output var  logic             CHIP_SEL_N,
    output var  logic             CMD_LATCH_EN,
    output var  logic             ADDR_LATCH_EN,
    output var  logic             WR_STROBE_N,
    output var  logic             RD_STROBE_N,
    output var  logic             WR_PROT_N,
    output var  logic [15:0]      IO_OUT,
    output var  logic             IO_OE,
    input  wire logic [15:0]      IO_IN,
    input  wire logic             READY_BUSY_N
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    nbc_state_e        state_q;                            // Bus cycle state
    nbc_state_e        state_d;                            // Next state
    nbc_req_s          req_q;                              // Request in work
    logic [2:0]        idx_q;                              // Address cycle index
    logic [CNT_W-1:0]  left_q;                             // Words still to read
    logic [3:0]        gap_q;                              // Settle countdown
    logic              tick;                               // Phase enable
    logic              f_ready;                            // Buffer has room
    logic              f_push;                             // Word into buffer
    logic [15:0]       f_data;                             // Sampled word
    logic [2:0]        ncyc;                               // Address cycles needed
    logic [7:0]        abyte;                              // Current address byte
    logic [15:0]       drive;                              // Lane value to drive
    logic              is_cmd;                             // Request is a code
    logic              is_adr;                             // Request is address

    assign is_cmd = req_q.kind == K_CMD;
    assign is_adr = req_q.kind == K_ADDR || req_q.kind == K_COL;
    // Surplus cycles are never sent; the fifth only on the large part
    assign ncyc = (req_q.kind == K_COL) ? ADDR_CYC_COL :
                  (BIG ? ADDR_CYC_BIG : ADDR_CYC_SMALL);

    // ****************************************************************
    // Lane values
    // ****************************************************************
    // Address byte for this cycle from the flat address
    always_comb begin
        if (X16) begin
            abyte = 8'(req_q.arg >> X16_LO[idx_q]) & X16_MSK[idx_q];
        end else begin
            abyte = 8'(req_q.arg >> X8_LO[idx_q]) & X8_MSK[idx_q];
        end
    end

    // Codes and addresses use only the low lanes
    always_comb begin
        if (req_q.kind == K_WR) begin
            drive = X16 ? req_q.arg[15:0] : {8'h00, req_q.arg[7:0]};
        end else if (is_cmd) begin
            drive = {8'h00, req_q.code};
        end else begin
            drive = {8'h00, abyte};
        end
    end

    // ****************************************************************
    // Submodules
    // ****************************************************************
    // Pin phase timing
    nbc_tick #(
        .DIV   (TICK_DIV)
    ) u_tick (
        .clk   (MCLK),
        .rst_n (RST_N),
        .tick  (tick)
    );

    // Sampled read word, high lanes cleared on the narrow part
    assign f_data = X16 ? IO_IN : {8'h00, IO_IN[7:0]};
    assign f_push = (state_q == S_RLO) && tick;

    // Read data buffer; a full buffer stalls the read strobe
    nbc_fifo #(
        .WIDTH     (FIFO_W),
        .DEPTH     (FIFO_D)
    ) u_fifo (
        .clk       (MCLK),
        .rst_n     (RST_N),
        .in_valid  (f_push),
        .in_data   (f_data),
        .in_ready  (f_ready),
        .out_valid (RD_VALID),
        .out_data  (RD_DATA),
        .out_ready (RD_READY)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Bus cycle sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                // Take a request whenever REQ_READY is high
                if (REQ_VALID && REQ_READY) begin
                    if (REQ.kind == K_RD) begin
                        state_d = (REQ.cnt == '0) ? S_IDLE : S_RLO;
                    end else begin
                        state_d = S_RDY;
                    end
                end
            end
            S_RDY: begin
                // Codes wait for ready unless allowed during busy
                if (tick && (!is_cmd || READY_BUSY_N || busy_ok(req_q.code))) begin
                    if (is_cmd && is_prog(req_q.code) && !WR_PROT_N) begin
                        state_d = S_WP;
                    end else begin
                        state_d = S_SET;
                    end
                end
            end
            S_WP: begin
                // One phase for protect to settle high
                if (tick) begin
                    state_d = S_SET;
                end
            end
            S_SET: begin
                // Strobe low phase done
                if (tick) begin
                    state_d = S_LAT;
                end
            end
            S_LAT: begin
                // Rising edge made, hold phase done
                if (tick) begin
                    state_d = S_GAP;
                end
            end
            S_GAP: begin
                // Next address cycle or finish after settle
                if (tick && gap_q == '0) begin
                    if (is_adr && idx_q < ncyc) begin
                        state_d = S_SET;
                    end else begin
                        state_d = S_IDLE;
                    end
                end
            end
            S_RLO: begin
                // Hold read strobe low until the buffer has room
                if (tick && f_ready) begin
                    state_d = S_RHI;
                end
            end
            S_RHI: begin
                // Next word or done
                if (tick) begin
                    state_d = (left_q == CNT_W'(1)) ? S_IDLE : S_RLO;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // State and request registers
    // ****************************************************************
    // State register
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Request capture and read word count
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            req_q  <= '0;
            left_q <= '0;
        end else if (state_q == S_IDLE && REQ_VALID && REQ_READY) begin
            req_q  <= REQ;
            left_q <= REQ.cnt;
        end else if (state_q == S_RHI && tick) begin
            left_q <= left_q - 1'b1;
        end
    end

    // Address cycle index, advanced after each latch edge so the
    // next byte is already selected when the strobe falls again
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            idx_q <= '0;
        end else if (state_q == S_IDLE) begin
            idx_q <= '0;
        end else if (state_q == S_LAT && tick && is_adr) begin
            idx_q <= idx_q + 3'h1;
        end
    end

    // Settle after a confirm code so busy is seen before the next code
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            gap_q <= '0;
        end else if (state_q == S_LAT && tick) begin
            gap_q <= (is_cmd && is_confirm(req_q.code)) ? 4'(TWB_CYC) : 4'h0;
        end else if (gap_q != '0) begin
            gap_q <= gap_q - 4'h1;
        end
    end

    // ****************************************************************
    // Pin registers
    // ****************************************************************
    // Select while working, standby when idle
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            CHIP_SEL_N <= 1'b1;
        end else begin
            CHIP_SEL_N <= state_d == S_IDLE;
        end
    end

    // Latch enables through the strobe and its hold phase
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            CMD_LATCH_EN  <= 1'b0;
            ADDR_LATCH_EN <= 1'b0;
        end else begin
            CMD_LATCH_EN  <= is_cmd && (state_d == S_SET || state_d == S_LAT);
            ADDR_LATCH_EN <= is_adr && (state_d == S_SET || state_d == S_LAT);
        end
    end

    // Write strobe low for one phase; rising edge latches the lanes
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            WR_STROBE_N <= 1'b1;
        end else begin
            WR_STROBE_N <= state_d != S_SET;
        end
    end

    // Read strobe low per word; high during every write cycle
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            RD_STROBE_N <= 1'b1;
        end else begin
            RD_STROBE_N <= state_d != S_RLO;
        end
    end

    // Lanes driven across strobe and hold, released for reads
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            IO_OUT <= '0;
            IO_OE  <= 1'b0;
        end else begin
            IO_OE <= state_d == S_SET || state_d == S_LAT;
            if (state_d == S_SET) begin
                IO_OUT <= drive;
            end
        end
    end

    // Protect high from a program code until a read-class or reset code
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            WR_PROT_N <= 1'b0;
        end else if (state_q == S_RDY && state_d == S_WP) begin
            WR_PROT_N <= 1'b1;
        end else if (state_q == S_LAT && tick && is_cmd && ends_prog(req_q.code)) begin
            WR_PROT_N <= 1'b0;
        end
    end

    // Request ready and device busy, both registered
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            REQ_READY <= 1'b0;
            DEV_BUSY  <= 1'b0;
        end else begin
            REQ_READY <= state_d == S_IDLE && !(state_q == S_IDLE && REQ_VALID && REQ_READY);
            DEV_BUSY  <= !READY_BUSY_N;
        end
    end
endmodule : nbc_host
`default_nettype wire

// ---- verilog/nbc_pkg.sv ----
// Constants, codes and types for the parallel flash host controller.
// Assumes a single 25 MHz clock; all pin timing is built from it.
// Contract
// - Data in: CE low, latches low, RE high
// - Data out: CE low, WE high, latches low
// - Host holds WP high for program/erase codes
// - x8 address cycle layout, five cycles max
// - x16 address cycles on low lanes only
// - Fifth address cycle only for large density
// - Command codes on low lanes, CLE high
// - High lanes carry only data cycles
// - Page read and random column output codes
// - Program sequences and random data input code
// - Copy-back and block erase code order
// - Cache read codes; exit accepted while busy
// - Lock and signature command codes
// - Command cycle strobe and latch levels
// - Address cycle levels; four or five cycles
package nbc_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_NS   = 40;                          // Clock period
    localparam int TWB_NS   = 100;                         // Strobe to busy
    localparam int TWB_CYC  = (TWB_NS + CLK_NS - 1) / CLK_NS; // Least, rounded up
    localparam int TICK_DIV = 2;                           // Cycles per pin phase

    // ****************************************************************
    // Sizes and address layout
    // ****************************************************************
    localparam int FIFO_W       = 16;                      // Read word width
    localparam int FIFO_D       = 8;                       // Read buffer depth
    localparam int ADDR_W       = 29;                      // Flat address width
    localparam int CNT_W        = 12;                      // Read word count width
    localparam logic [2:0] ADDR_CYC_SMALL = 3'h4;          // Small density
    localparam logic [2:0] ADDR_CYC_BIG   = 3'h5;          // Large density
    localparam logic [2:0] ADDR_CYC_COL   = 3'h2;          // Column only
    // Lowest address bit and lane mask of each address cycle
    localparam logic [4:0] X8_LO  [5] = '{5'h00, 5'h08, 5'h0c, 5'h14, 5'h1c};
    localparam logic [7:0] X8_MSK [5] = '{8'hff, 8'h0f, 8'hff, 8'hff, 8'h01};
    localparam logic [4:0] X16_LO [5] = '{5'h00, 5'h08, 5'h0b, 5'h13, 5'h1b};
    localparam logic [7:0] X16_MSK[5] = '{8'hff, 8'h07, 8'hff, 8'hff, 8'h01};
    // Where column, page and block start in the flat address
    localparam int X8_PAGE_LO   = 12;
    localparam int X8_BLOCK_LO  = 18;
    localparam int X16_PAGE_LO  = 11;
    localparam int X16_BLOCK_LO = 17;

    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_READ       = 8'h00;
    localparam logic [7:0] CMD_READ_GO    = 8'h30;
    localparam logic [7:0] CMD_RCOL       = 8'h05;
    localparam logic [7:0] CMD_RCOL_GO    = 8'he0;
    localparam logic [7:0] CMD_CREAD_GO   = 8'h31;
    localparam logic [7:0] CMD_CREAD_EXIT = 8'h34;
    localparam logic [7:0] CMD_PROG       = 8'h80;
    localparam logic [7:0] CMD_PROG_GO    = 8'h10;
    localparam logic [7:0] CMD_CPROG_GO   = 8'h15;
    localparam logic [7:0] CMD_RDIN       = 8'h85;
    localparam logic [7:0] CMD_CB_GO      = 8'h35;
    localparam logic [7:0] CMD_ERASE      = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO   = 8'hd0;
    localparam logic [7:0] CMD_RESET      = 8'hff;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_SIG        = 8'h90;
    localparam logic [7:0] CMD_LOCKST     = 8'h7a;
    localparam logic [7:0] CMD_UNLK_LO    = 8'h23;
    localparam logic [7:0] CMD_UNLK_HI    = 8'h24;
    localparam logic [7:0] CMD_LOCK       = 8'h2a;
    localparam logic [7:0] CMD_LOCKDN     = 8'h2c;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        K_CMD  = 3'h0,                                     // One command cycle
        K_ADDR = 3'h1,                                     // Full address
        K_COL  = 3'h2,                                     // Column address
        K_WR   = 3'h3,                                     // One data word in
        K_RD   = 3'h4                                      // Words out
    } nbc_kind_e;

    typedef struct packed {
        nbc_kind_e           kind;                         // Cycle kind
        logic [7:0]          code;                         // Command code
        logic [ADDR_W-1:0]   arg;                          // Address or data
        logic [CNT_W-1:0]    cnt;                          // Words to read
    } nbc_req_s;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,                                     // Deselected
        S_RDY  = 3'h1,                                     // Wait device ready
        S_WP   = 3'h2,                                     // Let protect settle
        S_SET  = 3'h3,                                     // Write strobe low
        S_LAT  = 3'h4,                                     // Write strobe high
        S_GAP  = 3'h5,                                     // Settle, then next cycle
        S_RLO  = 3'h6,                                     // Read strobe low
        S_RHI  = 3'h7                                      // Read strobe high
    } nbc_state_e;

    // ****************************************************************
    // Code classes
    // ****************************************************************
    // Codes that start or confirm a program or erase
    function automatic logic is_prog(input logic [7:0] c);
        return c == CMD_PROG || c == CMD_PROG_GO || c == CMD_CPROG_GO ||
               c == CMD_RDIN || c == CMD_ERASE || c == CMD_ERASE_GO;
    endfunction : is_prog

    // Codes that may be issued while the device is busy
    function automatic logic busy_ok(input logic [7:0] c);
        return c == CMD_RESET || c == CMD_STATUS || c == CMD_CREAD_EXIT;
    endfunction : busy_ok

    // Codes after which the device may drop ready
    function automatic logic is_confirm(input logic [7:0] c);
        return c == CMD_READ_GO || c == CMD_CREAD_GO || c == CMD_CB_GO ||
               c == CMD_PROG_GO || c == CMD_CPROG_GO || c == CMD_ERASE_GO ||
               c == CMD_RESET;
    endfunction : is_confirm

    // Codes that end any program or erase sequence
    function automatic logic ends_prog(input logic [7:0] c);
        return c == CMD_READ || c == CMD_RCOL || c == CMD_SIG ||
               c == CMD_LOCKST || c == CMD_RESET;
    endfunction : ends_prog

endpackage : nbc_pkg

// ---- verilog/nbc_tick.sv ----
// Phase tick divider: one-cycle enable every DIV clock cycles.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module nbc_tick #(
    parameter int DIV = 2
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output var  logic tick
);
    localparam int CW = $clog2(DIV + 1);

    logic [CW-1:0] cnt_q;                                  // Cycle count

    // ****************************************************************
    // Counter and pulse
    // ****************************************************************
    // Count to DIV-1, pulse once, wrap
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule : nbc_tick
`default_nettype wire

// ---- verilog/nbc_fifo.sv ----
// Read data FIFO with valid and ready on both sides.
// Assumes one clock, synchronous active-low reset, DEPTH a power of two.
`timescale 1ns/1ps
`default_nettype none
module nbc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             in_ready,
    output var  logic             out_valid,
    output var  logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];                         // Storage
    logic [AW-1:0]    wp_q;                                // Write pointer
    logic [AW-1:0]    rp_q;                                // Read pointer
    logic [AW:0]      cnt_q;                               // Fill level
    logic [AW:0]      cnt_d;                               // Next fill level
    logic             full_q;                              // Full flag
    logic             push;                                // Word taken
    logic             pop;                                 // Word given

    assign push     = in_valid && !full_q;
    assign pop      = out_valid && out_ready;
    assign in_ready = !full_q;
    assign out_data = mem[rp_q];

    // Next fill level
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    // Write the array
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointers, level and registered flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q      <= '0;
            rp_q      <= '0;
            cnt_q     <= '0;
            full_q    <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q     <= cnt_d;
            full_q    <= cnt_d == (AW+1)'(DEPTH);
            out_valid <= cnt_d != '0;
        end
    end
endmodule : nbc_fifo
`default_nettype wire

// ---- verification/nbc_host_monitor.sv ----
// Checker of the flash host's pin cycles and read buffer.
// Bound into nbc_host; sees its ports only, one clock.
`timescale 1ns/1ps
`default_nettype none
module nbc_host_mon (
    input wire logic        MCLK, RST_N, DEV_BUSY, RD_VALID, IO_OE, WR_PROT_N, CHIP_SEL_N,
    input wire logic        CMD_LATCH_EN, ADDR_LATCH_EN, WR_STROBE_N, RD_STROBE_N,
    input wire logic [15:0] IO_OUT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    latch_mode_a: assert property (CMD_LATCH_EN |-> !ADDR_LATCH_EN && RD_STROBE_N)
        else $error("both latches");
    read_cycle_a: assert property (!RD_STROBE_N |-> WR_STROBE_N && !IO_OE && !ADDR_LATCH_EN)
        else $error("read cycle");
    write_hold_a: assert property ($rose(WR_STROBE_N) |-> IO_OE && $stable(IO_OUT))
        else $error("write not held");
    high_lanes_a: assert property (CMD_LATCH_EN || ADDR_LATCH_EN |-> IO_OUT[15:8] == 8'h00)
        else $error("upper lanes");
    prot_high_a: assert property (!WR_STROBE_N && CMD_LATCH_EN && IO_OUT[7:0] inside
        {8'h80, 8'h85, 8'h10, 8'h15, 8'h60, 8'hd0} |-> WR_PROT_N) else $error("protect low");
    busy_codes_a: assert property ($fell(WR_STROBE_N) && CMD_LATCH_EN && DEV_BUSY |->
        IO_OUT[7:0] inside {8'hff, 8'h70, 8'h34}) else $error("code while busy");
    standby_a: assert property (CHIP_SEL_N |-> WR_STROBE_N && RD_STROBE_N)
        else $error("standby");
    word_push_a: assert property ($rose(RD_STROBE_N) |-> ##[0:1] RD_VALID)
        else $error("word lost");
endmodule : nbc_host_mon
bind nbc_host nbc_host_mon u_mon (.MCLK, .RST_N, .DEV_BUSY, .RD_VALID, .IO_OE, .WR_PROT_N,
    .CHIP_SEL_N, .CMD_LATCH_EN, .ADDR_LATCH_EN, .WR_STROBE_N, .RD_STROBE_N, .IO_OUT);
`default_nettype wire

// ---- verification/nbc_dev_model.sv ----
// Behavioural flash device on the host's pins.
// Samples on the falling clock, half a cycle after the host drives.
`timescale 1ns/1ps
`default_nettype none
module nbc_dev_model (
    input  wire logic        MCLK, CHIP_SEL_N, CMD_LATCH_EN, ADDR_LATCH_EN,
    input  wire logic        WR_STROBE_N, RD_STROBE_N, WR_PROT_N,
    input  wire logic [15:0] IO_OUT,
    output var  logic [15:0] IO_IN = 16'h0000,
    output var  logic        READY_BUSY_N
);
    logic [17:0] log_q [$];                // Latched {cmd, addr, lanes}
    logic        we_q = 1'h1, re_q = 1'h1; // Strobes one cycle ago
    logic [15:0] col_q = 16'h0000;         // Output column
    int          bz_q = 0;                 // Busy cycles left
    assign READY_BUSY_N = bz_q == 0;
    always @(negedge MCLK) begin
        we_q <= WR_STROBE_N;
        re_q <= RD_STROBE_N;
        bz_q <= bz_q > 0 ? bz_q - 1 : 0;
        if (!CHIP_SEL_N && WR_STROBE_N && !we_q && RD_STROBE_N) begin
            log_q.push_back({CMD_LATCH_EN, ADDR_LATCH_EN, IO_OUT});
            col_q <= 16'h0000;
            if (CMD_LATCH_EN && (IO_OUT[7:0] inside {8'h30, 8'h31, 8'h35, 8'hff} ||
                WR_PROT_N && IO_OUT[7:0] inside {8'h10, 8'h15, 8'hd0})) bz_q <= 30;
        end
        if (!CHIP_SEL_N && !RD_STROBE_N && re_q) begin
            col_q <= col_q + 16'h0001;
            IO_IN <= 16'hc301 + col_q; // set on the fall, held while low
        end else if (CHIP_SEL_N || RD_STROBE_N) IO_IN <= ~IO_IN;
    end
endmodule : nbc_dev_model
`default_nettype wire

// ---- verification/tb.sv ----
// Bench of the flash host against the behavioural device.
// Needs design, monitor and device model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import nbc_pkg::*;
    logic MCLK = 1'h0, RST_N = 1'h0, X16 = 1'h0, BIG = 1'h1, REQ_VALID = 1'h0, RD_READY = 1'h0;
    logic REQ_READY, RD_VALID, DEV_BUSY, CHIP_SEL_N, CMD_LATCH_EN, ADDR_LATCH_EN, IO_OE;
    logic WR_STROBE_N, RD_STROBE_N, WR_PROT_N, READY_BUSY_N;
    logic [15:0] RD_DATA, IO_OUT, IO_IN;
    nbc_req_s REQ = '0;
    int bad_count = 0, comparisons = 0, i, n;
    always #20 MCLK = ~MCLK;
    nbc_host dut (.*);
    nbc_dev_model u_dev (.*);
    task automatic close_out;
        if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    task automatic chk(input logic [17:0] s, e);
        comparisons++;
        if (s !== e) $display("CHECK FAILED %0t %h %h", $time, s, e);
        if (s !== e) bad_count++;
    endtask : chk
    task automatic wt(ref logic v, input logic l); // Bounded wait for a level
        for (i = 0; v !== l; i++) begin
            @(negedge MCLK);
            if (i == 600) begin
                bad_count++;
                close_out;
            end
        end
    endtask : wt
    task automatic send(input nbc_kind_e k, input logic [7:0] c, input logic [28:0] a);
        @(posedge MCLK);
        REQ <= '{k, c, a, 12'h009};
        REQ_VALID <= 1'h1;
        wt(REQ_READY, 1'h1);
        @(posedge MCLK);
        REQ_VALID <= 1'h0;
        wt(REQ_READY, 1'h0);
        if (k != K_RD) wt(REQ_READY, 1'h1);
    endtask : send
    task automatic cmpl(input logic [9:0] e [$]); // Device's latched cycles, low lanes
        foreach (e[j])
            chk(u_dev.log_q.pop_front() & 18'h300ff, {e[j][9:8], 8'h00, e[j][7:0]});
    endtask : cmpl
    task automatic sc_prog; // 8-bit large part: program, five address cycles
        send(K_CMD, 8'h80, 29'h0);
        send(K_ADDR, 8'h00, 29'h1abcdef5);
        send(K_WR, 8'h00, 29'h3c);
        send(K_CMD, 8'h10, 29'h0);
        cmpl('{10'h280, 10'h1f5, 10'h10e, 10'h1cd, 10'h1ab, 10'h101, 10'h03c, 10'h210});
    endtask : sc_prog
    task automatic sc_read; // 16-bit small part: nine words through eight places
        @(posedge MCLK);
        X16 <= 1'h1;
        BIG <= 1'h0;
        send(K_CMD, 8'h00, 29'h0);
        send(K_ADDR, 8'h00, 29'h0abc1234);
        send(K_CMD, 8'h30, 29'h0);
        cmpl('{10'h200, 10'h134, 10'h102, 10'h182, 10'h157, 10'h230});
        wt(READY_BUSY_N, 1'h1);
        send(K_RD, 8'h00, 29'h0);
        n = 0;
        for (i = 0; n < 6; i++) begin // Full: strobe stalls
            @(negedge MCLK);
            n = RD_STROBE_N ? 0 : n + 1;
            if (i == 600) bad_count++;
            if (i == 600) close_out;
        end
        for (int j = 0; j < 9; j++) begin
            wt(RD_VALID, 1'h1);
            chk({2'h0, RD_DATA}, 18'h0c301 + 18'(j));
            @(posedge MCLK);
            RD_READY <= 1'h1;
            @(posedge MCLK);
            RD_READY <= 1'h0;
            @(negedge MCLK);
        end
        send(K_CMD, 8'h05, 29'h0);
        send(K_COL, 8'h00, 29'h5a3);
        send(K_CMD, 8'he0, 29'h0);
        cmpl('{10'h205, 10'h1a3, 10'h105, 10'h2e0});
    endtask : sc_read
    task automatic sc_codes; // Other codes; 34, FF and 70 while busy
        logic [7:0] c [17] = '{8'h05, 8'he0, 8'h31, 8'h34, 8'h85, 8'h15, 8'h35, 8'h60,
            8'hd0, 8'hff, 8'h70, 8'h90, 8'h7a, 8'h23, 8'h24, 8'h2a, 8'h2c};
        foreach (c[j]) send(K_CMD, c[j], 29'h0);
        foreach (c[j]) cmpl('{{2'h2, c[j]}});
    endtask : sc_codes
    initial begin
        repeat (12) @(posedge MCLK);
        RST_N <= 1'h1;
        sc_prog;
        sc_read;
        sc_codes;
        close_out;
    end
endmodule : tb
`default_nettype wire
